// File: hw/sad_pkg.sv
// shared constants and types for the system address decoder
// assumes a 100 MHz fabric clock and a 1 MHz processor system clock pin
package sad_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // 4K block codes on address bits 15..12
  localparam logic [3:0] IO_BLK   = 4'h4;
  localparam logic [3:0] OPT_BLK  = 4'h5;
  // bit 15 set: program memory half
  localparam int         PROGRAM_MEMORY_ENABLE_N_BIT = 3;
  // pairs of 4K blocks on address bits 15..13
  localparam logic [2:0] RAM0_PAIR = 3'h0;
  localparam logic [2:0] RAM1_PAIR = 3'h1;
  // bits 15..14 zero: whole ram window
  localparam logic [1:0] RAM_QUAD  = 2'h0;

  // function decoder outputs, 32-byte blocks from the io base
  localparam int FN_REG      = 0;
  localparam int FN_BARGRAPH = 1;
  localparam int FN_COMMS    = 2;
  localparam int FN_ANALYZER = 3;
  localparam int FN_GPIB     = 4;
  localparam int FN_ANALOG   = 5;
  localparam int FN_SPARE1   = 6;
  localparam int FN_SPARE2   = 7;

  // read register map
  localparam logic [15:0] PANEL_SWITCH_INTERFACE = 16'h4000;
  localparam logic [15:0] ENTRY_SWITCH_BYTE      = 16'h4002;
  localparam logic [15:0] PULSE_COUNT_LOW_BYTE   = 16'h4004;
  localparam logic [15:0] PULSE_COUNT_HIGH_BYTE  = 16'h4006;
  localparam logic [15:0] RANGE_SELECT_INPUT     = 16'h4008;
  localparam int RD_SWITCH = 0;
  localparam int RD_ENTRY  = 1;
  localparam int RD_CNT_LO = 2;
  localparam int RD_CNT_HI = 3;
  localparam int RD_RANGE  = 4;

  // entry switch byte layout
  localparam int ENTRY_ENTER_BIT  = 0;
  localparam int ENTRY_VALUE_BIT  = 1;
  localparam int ENTRY_DIGIT_BIT  = 2;
  localparam int ENTRY_UNUSED_BIT = 3;
  localparam int ENTRY_FUNC_LSB   = 4;

  // reset values
  localparam logic [7:0] SELECT_IDLE = 8'hFF;
  localparam logic       SEL_OFF     = 1'b1;
  localparam logic [7:0] DATA_IDLE   = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SYS_CLK_HIGH_NS = 500;
  localparam int STROBE_LEAD_NS  = 225;
  localparam int STROBE_WIDTH_NS = 225;
  localparam logic [5:0] STROBE_START_CYC =
    6'((SYS_CLK_HIGH_NS - STROBE_LEAD_NS) / CLK_PERIOD_NS);
  localparam logic [5:0] STROBE_WIDTH_CYC =
    6'((STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_LEAD  = 2'b01,
    SP_PULSE = 2'b11,
    SP_DONE  = 2'b10
  } sad_phase_type;

  typedef enum logic [3:0] {
    FC_HIGH_SETPOINT = 4'hF,
    FC_CALIBRATE     = 4'hE,
    FC_WARN          = 4'hD,
    FC_OVERRANGE     = 4'hB,
    FC_CONV_CONST    = 4'h9,
    FC_TAU           = 4'h7,
    FC_FULL_SCALE    = 4'h5,
    FC_LOW_SCALE     = 4'h1
  } sad_func_code_type;

endpackage

// File: hw/sad_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module sad_pin_sync
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
)
(
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          s1_reg[g]  <= INIT[g];
          s2_reg[g]  <= INIT[g];
          s3_reg[g]  <= INIT[g];
          level_o[g] <= INIT[g];
        end
        else
        begin
          s1_reg[g] <= pin_i[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          // glitch filter: take the level once two late stages agree
          if (s2_reg[g] == s3_reg[g])
            level_o[g] <= s3_reg[g];
        end
      end
    end
  endgenerate

endmodule

// File: hw/sad_top.sv
// main-board bus glue: write strobe, transceiver steering, address decode
// assumes processor pins arrive asynchronously; all are filtered first
//
// Overview of operation
// - make a 230 ns (23-cycle) write strobe ending at the clock fall, true and inverted
// - internal transceiver feeds processor on read, internal bus on write
// - external transceiver moves data only while option board enable is low
// - external path: external to internal on read, internal to external on write
// - address bits 15..12 with read/write give active-low 4K selects
// - program memory enable on reads of 8000-FFFF, no clock gating
// - ram selects 0000-1FFF and 2000-3FFF; ram read/write strobes 0000-3FFF
// - ram read strobe and ram chip selects only during clock high phase
// - ram write only while the write strobe is active
// - io select for 4000-4FFF; separate select for 5000-5FFF to connector
// - io region split by bits 8..5 into 32-byte active-low selects
// - selects 4040 through 40E0 go out to option boards
// - register block read decode uses bits 3..1, one output per even address
// - reads map switches, entry, counter low/high, range; rest spare
// - entry byte: enter, value, digit switches, bit 3 zero, function code
// - function codes F,E,D,B,9,7,5,1 are defined, others undefined
// - register block write decode with strobe, bits 3..1 select outputs
`timescale 1ns/1ps
module sad_top
  import sad_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sys_clk_i,
  input  wire logic        rw_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        ext_bus_enable_n_i,
  input  wire logic [7:0]  cpu_data_i,
  input  wire logic [7:0]  int_data_i,
  input  wire logic [7:0]  ext_data_i,
  input  wire logic        enter_sw_n_i,
  input  wire logic        value_sw_n_i,
  input  wire logic        digit_sw_n_i,
  input  wire logic [3:0]  func_code_i,
  output logic             write_strobe_o,
  output logic             write_strobe_n_o,
  output logic             program_memory_enable_n_o,
  output logic             ram_primary_sel_n_o,
  output logic             ram_expansion_sel_n_o,
  output logic             ram_read_n_o,
  output logic             ram_write_n_o,
  output logic             io_region_sel_n_o,
  output logic             option_5000_sel_n_o,
  output logic [7:0]       function_select_n_o,
  output logic [7:0]       read_reg_sel_n_o,
  output logic [7:0]       write_reg_sel_n_o,
  output logic [7:0]       cpu_data_o,
  output logic             cpu_data_oe_o,
  output logic [7:0]       int_data_o,
  output logic             int_data_oe_o,
  output logic [7:0]       ext_data_o,
  output logic             ext_data_oe_o,
  output logic             func_code_defined_o
);

  function automatic logic [7:0] onehot_n(input logic [2:0] idx);
    onehot_n = ~(8'h01 << idx);
  endfunction
  logic        sys_clk_s;
  logic        rw_s;
  logic [15:0] addr_s;
  logic        ext_en_n_s;
  logic [7:0]  cpu_s;
  logic [7:0]  int_s;
  logic [7:0]  ext_s;
  logic [6:0]  panel_s;

  sad_pin_sync #(.WIDTH(19), .INIT({1'b0, 1'b1, 1'b1, 16'h0000})) u_ctl_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .pin_i   ({sys_clk_i, rw_i, ext_bus_enable_n_i, addr_i}),
    .level_o ({sys_clk_s, rw_s, ext_en_n_s, addr_s})
  );
  sad_pin_sync #(.WIDTH(24), .INIT(24'h00_0000)) u_data_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .pin_i   ({cpu_data_i, int_data_i, ext_data_i}),
    .level_o ({cpu_s, int_s, ext_s})
  );
  sad_pin_sync #(.WIDTH(7), .INIT(7'h07)) u_panel_sync
  (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .pin_i   ({func_code_i, digit_sw_n_i, value_sw_n_i, enter_sw_n_i}),
    .level_o (panel_s)
  );

  // write strobe phase machine, timed from the system clock rise
  sad_phase_type phase_reg;
  sad_phase_type phase_next;
  logic [5:0]    cnt_reg;
  logic [5:0]    cnt_next;
  logic          sys_clk_d_reg;
  logic          clk_rise;
  logic          strobe_next;
  assign clk_rise = sys_clk_s && !sys_clk_d_reg;

  always_comb
  begin
    phase_next = phase_reg;
    cnt_next   = cnt_reg + 6'h01;
    case (phase_reg)
      SP_IDLE:
      begin
        cnt_next = 6'h00;
        if (clk_rise)
          phase_next = SP_LEAD;
      end
      SP_LEAD:
      begin
        if (!sys_clk_s)
          phase_next = SP_IDLE;
        else if (cnt_reg == STROBE_START_CYC - 6'h02)
        begin
          phase_next = SP_PULSE;
          cnt_next   = 6'h00;
        end
      end
      SP_PULSE:
      begin
        // strobe closes on its own count, or early if the clock falls
        if (cnt_reg == STROBE_WIDTH_CYC - 6'h01)
          phase_next = SP_DONE;
        else if (!sys_clk_s)
          phase_next = SP_IDLE;
      end
      SP_DONE:
      begin
        cnt_next = 6'h00;
        if (!sys_clk_s)
          phase_next = SP_IDLE;
      end
      default:
      begin
        phase_next = SP_IDLE;
        cnt_next   = 6'h00;
      end
    endcase
    strobe_next = (phase_next == SP_PULSE);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phase_reg        <= SP_IDLE;
      cnt_reg          <= 6'h00;
      sys_clk_d_reg    <= 1'b0;
      write_strobe_o   <= 1'b0;
      write_strobe_n_o <= SEL_OFF;
    end
    else
    begin
      phase_reg        <= phase_next;
      cnt_reg          <= cnt_next;
      sys_clk_d_reg    <= sys_clk_s;
      write_strobe_o   <= strobe_next;
      write_strobe_n_o <= !strobe_next;
    end
  end

  // address decode
  logic [3:0] blk;
  logic       ram_any;
  logic       program_memory_enable_n_next;
  logic       ram0_next;
  logic       ram1_next;
  logic       ramrd_next;
  logic       ramwr_next;
  logic       io_next;
  logic       opt_next;
  logic [7:0] fn_next;
  logic [7:0] rd_next;
  logic [7:0] wr_next;
  always_comb
  begin
    blk        = addr_s[15:12];
    ram_any    = (blk[3:2] == RAM_QUAD);
    program_memory_enable_n_next  = !(rw_s && blk[PROGRAM_MEMORY_ENABLE_N_BIT]);
    ram0_next  = !((blk[3:1] == RAM0_PAIR) && sys_clk_s);
    ram1_next  = !((blk[3:1] == RAM1_PAIR) && sys_clk_s);
    ramrd_next = !(ram_any && rw_s && sys_clk_s);
    ramwr_next = !(ram_any && !rw_s && strobe_next);
    io_next    = !(blk == IO_BLK);
    opt_next   = !(blk == OPT_BLK);
    fn_next    = SELECT_IDLE;
    if ((blk == IO_BLK) && sys_clk_s && !addr_s[8])
      fn_next = onehot_n(addr_s[7:5]);
    rd_next = SELECT_IDLE;
    if (!fn_next[FN_REG] && rw_s)
      rd_next = onehot_n(addr_s[3:1]);
    wr_next = SELECT_IDLE;
    if (!fn_next[FN_REG] && !rw_s && strobe_next)
      wr_next = onehot_n(addr_s[3:1]);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      program_memory_enable_n_o <= SEL_OFF;
      ram_primary_sel_n_o       <= SEL_OFF;
      ram_expansion_sel_n_o     <= SEL_OFF;
      ram_read_n_o              <= SEL_OFF;
      ram_write_n_o             <= SEL_OFF;
      io_region_sel_n_o         <= SEL_OFF;
      option_5000_sel_n_o       <= SEL_OFF;
      function_select_n_o       <= SELECT_IDLE;
      read_reg_sel_n_o          <= SELECT_IDLE;
      write_reg_sel_n_o         <= SELECT_IDLE;
    end
    else
    begin
      program_memory_enable_n_o <= program_memory_enable_n_next;
      ram_primary_sel_n_o       <= ram0_next;
      ram_expansion_sel_n_o     <= ram1_next;
      ram_read_n_o              <= ramrd_next;
      ram_write_n_o             <= ramwr_next;
      io_region_sel_n_o         <= io_next;
      option_5000_sel_n_o       <= opt_next;
      // upper six outputs leave for the option connector untouched
      function_select_n_o       <= fn_next;
      read_reg_sel_n_o          <= rd_next;
      write_reg_sel_n_o         <= wr_next;
    end
  end

  // transceiver steering and entry switch byte
  logic [7:0] entry_byte;
  logic       ext_en;
  logic       int_oe_next;
  logic [7:0] int_out_next;
  always_comb
  begin
    entry_byte                   = {panel_s[6:3], 1'b0, panel_s[2:0]};
    ext_en                       = !ext_en_n_s;
    int_oe_next                  = 1'b1;
    int_out_next                 = cpu_s;
    if (rw_s)
    begin
      if (ext_en)
        int_out_next = ext_s;
      else if (!rd_next[RD_ENTRY])
        int_out_next = entry_byte;
      else
      begin
        // nothing on board drives the bus here; memories do it themselves
        int_oe_next  = 1'b0;
        int_out_next = DATA_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cpu_data_o    <= DATA_IDLE;
      cpu_data_oe_o <= 1'b0;
      int_data_o    <= DATA_IDLE;
      int_data_oe_o <= 1'b0;
      ext_data_o    <= DATA_IDLE;
      ext_data_oe_o <= 1'b0;
    end
    else
    begin
      cpu_data_oe_o <= rw_s;
      cpu_data_o    <= int_oe_next ? int_out_next : int_s;
      int_data_oe_o <= int_oe_next;
      int_data_o    <= int_out_next;
      ext_data_oe_o <= ext_en && !rw_s;
      ext_data_o    <= cpu_s;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      func_code_defined_o <= 1'b0;
    else
    begin
      case (panel_s[6:3])
        FC_HIGH_SETPOINT, FC_CALIBRATE, FC_WARN, FC_OVERRANGE,
        FC_CONV_CONST, FC_TAU, FC_FULL_SCALE, FC_LOW_SCALE:
          func_code_defined_o <= 1'b1;
        default:
          func_code_defined_o <= 1'b0;
      endcase
    end
  end

  // helper: length of the current strobe pulse
  logic [5:0] strobe_len_reg;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      strobe_len_reg <= 6'h00;
    else
      strobe_len_reg <= write_strobe_o ? strobe_len_reg + 6'h01 : 6'h00;
  end
  a_strobe_width: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($fell(write_strobe_o) && phase_reg == SP_DONE) |-> (strobe_len_reg == STROBE_WIDTH_CYC))
    else $error("write strobe width wrong");
  a_strobe_pair: assert property (@(posedge clk_i) disable iff (!nrst_i)
    write_strobe_n_o == !write_strobe_o) else $error("strobe copies disagree");
  a_program_memory_enable_n_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rw_s && addr_s[15]) |=> !program_memory_enable_n_o) else $error("memory enable missing");
  a_ram_read_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ram_read_n_o |-> ($past(sys_clk_s) && $past(rw_s) && $past(addr_s[15:14]) == 2'b00))
    else $error("ram read strobe outside clock phase");
  a_ram_write_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ram_write_n_o |-> (write_strobe_o && !$past(rw_s))) else $error("ram write outside strobe");
  a_ram_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_s[15:13] == 3'b001 && sys_clk_s) |=> (!ram_expansion_sel_n_o && ram_primary_sel_n_o))
    else $error("expansion ram select wrong");
  a_func_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_s[15:12] == 4'h4 && sys_clk_s && !addr_s[8])
      |=> (function_select_n_o == onehot_n($past(addr_s[7:5]))))
    else $error("function select wrong");
  a_no_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (addr_s[15:13] == 3'b011) |=> (function_select_n_o == 8'hFF && ram_read_n_o
      && ram_write_n_o && io_region_sel_n_o && option_5000_sel_n_o
      && read_reg_sel_n_o == 8'hFF && write_reg_sel_n_o == 8'hFF))
    else $error("select active outside any range");
  a_read_reg: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !read_reg_sel_n_o[RD_ENTRY] |-> (!function_select_n_o[FN_REG] && $past(rw_s)
      && $past(addr_s[3:1]) == 3'h1))
    else $error("read register select wrong");
  a_ext_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ext_data_oe_o |-> ($past(ext_en_n_s) == 1'b0 && !cpu_data_oe_o))
    else $error("external bus driven without enable");

endmodule

// File: verification/sad_cpu_model.sv
// processor and option board stand-in: one bus cycle per start_cycle/end_cycle pair, 500 ns e high
// assumes a 100 MHz clk_i; the bench calls start_cycle, then end_cycle
`timescale 1ns/1ps
module sad_cpu_model
(
  input  wire logic        clk_i,
  output logic             sys_clk_o,
  output logic             rw_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       cpu_data_o,
  output logic             ext_bus_enable_n_o,
  output logic [7:0]       ext_data_o
);
  initial
  begin
    sys_clk_o          = 1'b0;
    rw_o               = 1'b1;
    addr_o             = 16'h0000;
    cpu_data_o         = 8'h00;
    ext_bus_enable_n_o = 1'b1;
    ext_data_o         = 8'h00;
  end

  // address and direction settle 100 ns before e rises
  task automatic start_cycle(input logic [15:0] a, input logic r,
                             input logic [7:0] d, input logic opt);
    @(posedge clk_i);
    addr_o             <= a;
    rw_o               <= r;
    // released data lines flip, so a stale value never matches
    cpu_data_o         <= r ? ~cpu_data_o : d;
    ext_data_o         <= (opt && r) ? d : ~ext_data_o;
    ext_bus_enable_n_o <= ~opt;
    repeat (10) @(posedge clk_i);
    sys_clk_o          <= 1'b1;
  endtask

  task automatic end_cycle();
    @(posedge clk_i);
    sys_clk_o          <= 1'b0;
    ext_bus_enable_n_o <= 1'b1;
    repeat (30) @(posedge clk_i);
  endtask
endmodule

// File: verification/test_system_address_decoder.sv
// bench for the bus glue: address sweep and panel switch codes
// assumes sad_top and sad_cpu_model; samples 29, 40 and 80 cycles into a cycle
`timescale 1ns/1ps
module test_system_address_decoder
  import sad_pkg::*;
;
  logic       clk_i;
  logic       nrst_i;
  logic       sys_clk, rw, ext_en_n;
  logic [15:0] addr;
  logic [7:0] cpu_d, ext_d, int_data_i;
  logic       enter_sw_n_i, value_sw_n_i, digit_sw_n_i;
  logic [3:0] func_code_i, cv;
  logic       ws, ws_n, program_memory_enable_n_n, ram0_n, ram1_n, rd_n, wr_n, io_n, opt_n, def;
  logic [7:0] fs_n, rs_n, wrs_n, cpu_do, int_do, ext_do;
  logic       cpu_oe, int_oe, ext_oe;
  logic [7:0] sng, oe;
  int         err_total;
  int         n_compared;

  assign sng = {ws, program_memory_enable_n_n, ram0_n, ram1_n, rd_n, wr_n, io_n, opt_n};
  assign oe  = {5'h00, cpu_oe, int_oe, ext_oe};

  sad_cpu_model cpu (.clk_i(clk_i), .sys_clk_o(sys_clk), .rw_o(rw), .addr_o(addr),
    .cpu_data_o(cpu_d), .ext_bus_enable_n_o(ext_en_n), .ext_data_o(ext_d));

  sad_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .sys_clk_i(sys_clk), .rw_i(rw),
    .addr_i(addr), .ext_bus_enable_n_i(ext_en_n), .cpu_data_i(cpu_d),
    .int_data_i(int_data_i), .ext_data_i(ext_d), .enter_sw_n_i(enter_sw_n_i),
    .value_sw_n_i(value_sw_n_i), .digit_sw_n_i(digit_sw_n_i),
    .func_code_i(func_code_i), .write_strobe_o(ws), .write_strobe_n_o(ws_n),
    .program_memory_enable_n_o(program_memory_enable_n_n), .ram_primary_sel_n_o(ram0_n),
    .ram_expansion_sel_n_o(ram1_n), .ram_read_n_o(rd_n), .ram_write_n_o(wr_n),
    .io_region_sel_n_o(io_n), .option_5000_sel_n_o(opt_n),
    .function_select_n_o(fs_n), .read_reg_sel_n_o(rs_n), .write_reg_sel_n_o(wrs_n),
    .cpu_data_o(cpu_do), .cpu_data_oe_o(cpu_oe), .int_data_o(int_do),
    .int_data_oe_o(int_oe), .ext_data_o(ext_do), .ext_data_oe_o(ext_oe),
    .func_code_defined_o(def));

  // address, read flag, option board flag
  localparam logic [17:0] TBL [21] = '{
    {16'h0010, 2'b10}, {16'h0010, 2'b00}, {16'h1FFF, 2'b00}, {16'h2000, 2'b10},
    {16'h3FFF, 2'b00}, {16'h4000, 2'b10}, {16'h400E, 2'b10}, {16'h400A, 2'b00},
    {16'h4000, 2'b00}, {16'h4020, 2'b00}, {16'h4060, 2'b11}, {16'h40A0, 2'b01},
    {16'h40E0, 2'b10}, {16'h4100, 2'b10}, {16'h4F02, 2'b00}, {16'h5000, 2'b11},
    {16'h5FFF, 2'b01}, {16'h6000, 2'b10}, {16'h7FFF, 2'b00}, {16'h8000, 2'b10},
    {16'hFFFF, 2'b00}};

  initial
  begin
    clk_i = 1'b0;
    nrst_i = 1'b0;
    int_data_i = 8'h00;
    enter_sw_n_i = 1'b1;
    value_sw_n_i = 1'b1;
    digit_sw_n_i = 1'b1;
    func_code_i = 4'h0;
    err_total = 0;
    n_compared = 0;
  end

  always #5 clk_i = ~clk_i;

  function automatic logic [7:0] oh_n(input logic [2:0] i);
    return ~(8'h01 << i);
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic run(input logic [17:0] t);
    logic [15:0] a;
    logic        r, o, io, rg;
    logic [7:0]  d, ent, fs, sa;
    a  = t[17:2];
    r  = t[1];
    o  = t[0];
    d  = a[7:0] ^ a[15:8] ^ 8'h3C;
    io = (a[15:12] == IO_BLK) && !a[8];
    rg = io && (a[7:5] == 3'h0);
    fs = io ? oh_n(a[7:5]) : SELECT_IDLE;
    sa = {1'b0, !(a[15] && r), a[15:13] != RAM0_PAIR, a[15:13] != RAM1_PAIR,
          !(a[15:14] == RAM_QUAD && r), 1'b1, a[15:12] != IO_BLK, a[15:12] != OPT_BLK};
    @(posedge clk_i);
    int_data_i <= r ? ~d : ~int_data_i;
    cpu.start_cycle(a, r, d, o);
    wait_n(29);
    ent = {func_code_i, 1'b0, digit_sw_n_i, value_sw_n_i, enter_sw_n_i};
    chk(sng, sa, "selects early");
    chk(fs_n, fs, "function selects");
    chk(rs_n, (rg && r) ? oh_n(a[3:1]) : SELECT_IDLE, "read regs");
    chk(wrs_n, SELECT_IDLE, "write regs early");
    chk({7'h00, def}, {7'h00, (cv[0] && cv != 4'h3) || cv == 4'hE}, "code");
    if (r && a == ENTRY_SWITCH_BYTE)
    begin
      chk(cpu_do, ent, "entry byte");
      chk(oe, 8'h06, "entry oe");
    end
    else if (r && o)
    begin
      chk(cpu_do, d, "ext read");
      chk(oe, 8'h06, "ext read oe");
    end
    else if (r)
    begin
      chk(cpu_do, ~d, "int read");
      chk(oe, 8'h04, "int read oe");
    end
    else
    begin
      chk(int_do, d, "int write");
      chk(oe, {7'h01, o}, "write oe");
      if (o)
        chk(ext_do, d, "ext write");
    end
    wait_n(11);
    chk(sng, {1'b1, sa[6:3], !(a[15:14] == RAM_QUAD && !r), sa[1:0]}, "strobe");
    chk({7'h00, ws_n}, 8'h00, "strobe inverse");
    chk(wrs_n, (rg && !r) ? oh_n(a[3:1]) : SELECT_IDLE, "write regs");
    wait_n(9);
    cpu.end_cycle();
    #1;
    chk(sng, {1'b0, sa[6], 4'hF, sa[1:0]}, "selects e low");
    chk(fs_n & rs_n & wrs_n, SELECT_IDLE, "fn selects e low");
    chk({7'h00, ws_n}, 8'h01, "strobe inverse idle");
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    cv = 4'h0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    wait_n(6);
    for (int i = 0; i < 21; i++)
      run(TBL[i]);
    $display("test decode sweep done");
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clk_i);
      cv = 4'(c);
      func_code_i  <= cv;
      enter_sw_n_i <= cv[0];
      value_sw_n_i <= cv[1];
      digit_sw_n_i <= cv[2];
      run({ENTRY_SWITCH_BYTE, 2'b10});
    end
    $display("test entry switch codes done");
    conclude();
  end

  initial
  begin
    #200000;
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end
endmodule
